// ---- hdl/clk_out_cfg_pkg.sv ----
`default_nettype none
package clk_out_cfg_pkg;

  // serial word: register number in the low nibble
  localparam int ADDR_LSB        = 0;
  localparam int ADDR_W          = 4;
  localparam int WORD_W          = 32;
  localparam int NUM_CH          = 4;

  localparam logic [3:0] ADDR_CH_FIRST   = 4'h0;
  localparam logic [3:0] ADDR_CH_LAST    = 4'h7;
  localparam logic [3:0] ADDR_LOCK_SCALE = 4'hB;
  localparam logic [3:0] ADDR_LOOP_REF   = 4'hD;
  localparam logic [3:0] ADDR_REF_GLOBAL = 4'hE;
  localparam logic [3:0] ADDR_FB_PUMP    = 4'hF;

  // field positions
  localparam int SOFT_RESET_BIT = 31;
  localparam int PATH_LSB       = 17;
  localparam int CH_ON_BIT      = 16;
  localparam int DIV_LSB        = 8;
  localparam int DLY_LSB        = 4;
  localparam int PRESCALE_BIT   = 15;
  localparam int REF_MHZ_LSB    = 14;
  localparam int LOOP_LSB       = 4;
  localparam int FOUT_BIT       = 28;
  localparam int GATE_BIT       = 27;
  localparam int SLEEP_BIT      = 26;
  localparam int LOCK_SEL_LSB   = 20;
  localparam int REF_DIV_LSB    = 8;
  localparam int PUMP_LSB       = 30;
  localparam int OSC_DIV_LSB    = 26;
  localparam int FB_DIV_LSB     = 8;

  typedef enum logic [1:0] {
    PATH_BYPASS  = 2'h0,
    PATH_DIVIDED = 2'h1,
    PATH_DELAYED = 2'h2,
    PATH_BOTH    = 2'h3
  } path_t;

  // lock pin modes
  localparam logic [3:0] LOCK_OFF     = 4'h0;
  localparam logic [3:0] LOCK_HIGH    = 4'h1;
  localparam logic [3:0] LOCK_LOW     = 4'h2;
  localparam logic [3:0] LOCK_DIG_HI  = 4'h3;
  localparam logic [3:0] LOCK_DIG_LO  = 4'h4;
  localparam logic [3:0] LOCK_ANALOG  = 4'h5;
  localparam logic [3:0] LOCK_OD_NMOS = 4'h6;
  localparam logic [3:0] LOCK_OD_PMOS = 4'h7;

  // added path delays in ps relative to bypass
  localparam logic [11:0] DLY_DIVIDED_PS = 12'h064;
  localparam logic [11:0] DLY_DELAYED_PS = 12'h190;
  localparam logic [11:0] DLY_BOTH_PS    = 12'h1F4;
  localparam logic [11:0] DLY_STEP_PS    = 12'h096;

  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  typedef struct packed {
    path_t       path;
    logic        on;
    logic [7:0]  div;
    logic [3:0]  dly;
  } chan_cfg_t;

  typedef struct packed {
    chan_cfg_t [NUM_CH-1:0] ch;
    logic        prescale;
    logic [7:0]  ref_mhz;
    logic [9:0]  loop_filter;
    logic        fout_on;
    logic        gate;
    logic        sleep;
    logic [3:0]  lock_sel;
    logic [11:0] ref_div;
    logic [1:0]  pump;
    logic [3:0]  osc_div;
    logic [17:0] fb_div;
  } cfg_t;

  localparam chan_cfg_t CH_RESET = '{path: PATH_BYPASS, on: 1'b0, div: 8'h01, dly: 4'h0};

  localparam cfg_t CFG_RESET = '{
    ch:          {NUM_CH{CH_RESET}},
    prescale:    1'b0,
    ref_mhz:     8'h0A,
    loop_filter: 10'h000,
    fout_on:     1'b0,
    gate:        1'b1,
    sleep:       1'b0,
    lock_sel:    4'h0,
    ref_div:     12'h00A,
    pump:        2'h0,
    osc_div:     4'h2,
    fb_div:      18'h002F8
  };

endpackage
`default_nettype wire

// ---- hdl/clk_channel_path.sv ----
`timescale 1ns/1ps
`default_nettype none
module clk_channel_path (
  input  wire logic                      i_clk,
  input  wire logic                      i_arst_n,
  input  wire logic                      i_vco_tick,
  input  wire logic                      i_vco_lvl,
  input  wire logic                      i_align,
  input  wire logic                      i_allow,
  input  wire clk_out_cfg_pkg::chan_cfg_t i_cfg,
  output logic                           o_clk,
  output logic [11:0]                    o_added_delay_ps
);

  typedef struct packed {
    logic [8:0]  cnt;
    logic        div_lvl;
    logic        out;
    logic [11:0] dly_ps;
  } ch_st_t;

  ch_st_t st_q;
  ch_st_t st_d;
  logic [8:0] wrap;

  assign wrap = {i_cfg.div, 1'b0} - 9'h001;

  always_comb begin
    st_d = st_q;
    if (i_align) begin
      st_d.cnt     = 9'h000;
      st_d.div_lvl = 1'b0;
    end else if (i_vco_tick && i_cfg.div != 8'h00) begin
      if (st_q.cnt >= wrap) begin
        st_d.cnt     = 9'h000;
        st_d.div_lvl = ~st_q.div_lvl;
      end else begin
        st_d.cnt = st_q.cnt + 9'h001;
      end
    end
    // divider only in the path for divided modes
    st_d.out = i_allow && i_cfg.on && (i_cfg.path[0] ? st_q.div_lvl : i_vco_lvl);
    unique case (i_cfg.path)
      clk_out_cfg_pkg::PATH_BYPASS:  st_d.dly_ps = 12'h000;
      clk_out_cfg_pkg::PATH_DIVIDED: st_d.dly_ps = clk_out_cfg_pkg::DLY_DIVIDED_PS;
      clk_out_cfg_pkg::PATH_DELAYED: st_d.dly_ps = clk_out_cfg_pkg::DLY_DELAYED_PS
                                      + 12'(i_cfg.dly) * clk_out_cfg_pkg::DLY_STEP_PS;
      clk_out_cfg_pkg::PATH_BOTH:    st_d.dly_ps = clk_out_cfg_pkg::DLY_BOTH_PS
                                      + 12'(i_cfg.dly) * clk_out_cfg_pkg::DLY_STEP_PS;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_clk            = st_q.out;
  assign o_added_delay_ps = st_q.dly_ps;

  property p_bypass_follows;
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_allow && i_cfg.on && i_cfg.path == clk_out_cfg_pkg::PATH_BYPASS) |=> (o_clk == $past(i_vco_lvl));
  endproperty
  a_bypass_follows: assert property (p_bypass_follows) else $error("bypass output not following vco level");

  property p_div_wrap;
    @(posedge i_clk) disable iff (!i_arst_n)
    (!i_align && i_vco_tick && i_cfg.div != 8'h00 && st_q.cnt == wrap) |=> (st_q.div_lvl != $past(st_q.div_lvl));
  endproperty
  a_div_wrap: assert property (p_div_wrap) else $error("divided level did not toggle at 2*code ticks");

  c_divided_toggle: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    i_cfg.path == clk_out_cfg_pkg::PATH_DIVIDED && $rose(o_clk));

endmodule
`default_nettype wire

// ---- hdl/clock_output_path_config.sv ----
// Functional notes
// - writing one to bit 31 of register 0 restores all power-on defaults
// - a soft reset write ignores its other fields; host rewrites register after
// - four identical channels 0..3, each with path, divider, delay, enable
// - path select bits 18:17: bypass, divided, delayed, both; default bypass
// - added delay: divided 100 ps, delayed 400 ps, both 500 ps plus code
// - the channel divider acts only in divided or divided-and-delayed paths
// - divider code bits 15:8 divide by twice code, 2..510, default 1
// - channel dividers are fed from the oscillator divider output
// - all-outputs gate, bit 27 of register 14, defaults to one
// - sleep bit 26 of register 14 defaults zero; one powers the chip down
// - lock pin selector bits 23:20 of register 14 defaults zero, pin off
// - reference input field bits 21:14 of register 13, whole MHz, default 10
// - lock detect prescale bit 15 of register 11 defaults to zero
// - prescale one divides the lock detect event rate by four
// - gate zero or enable pin low disables every channel clock output
`timescale 1ns/1ps
`default_nettype none
module clock_output_path_config (
  input  wire logic                                   i_clk,
  input  wire logic                                   i_arst_n,
  input  wire logic                                   i_wire_clk,
  input  wire logic                                   i_wire_data,
  input  wire logic                                   i_wire_latch,
  input  wire logic                                   i_align_n,
  input  wire logic                                   i_output_enable_pin,
  input  wire logic                                   i_pd_tick,
  input  wire logic                                   i_lock_detect,
  output logic [clk_out_cfg_pkg::NUM_CH-1:0]          o_clk_out,
  output logic [clk_out_cfg_pkg::NUM_CH-1:0][11:0]    o_added_delay_ps,
  output logic                                        o_oscillator_divide_code_clk,
  output logic                                        o_fout_on,
  output logic                                        o_chip_sleep,
  output logic                                        o_lock_tick,
  output logic                                        o_lock_pin_o,
  output logic                                        o_lock_pin_oe,
  output logic [7:0]                                  o_ref_input_mhz,
  output logic [9:0]                                  o_loop_filter,
  output logic [11:0]                                 o_ref_div,
  output logic [17:0]                                 o_fb_div,
  output logic [1:0]                                  o_pump_current_code
);

  typedef struct packed {
    clk_out_cfg_pkg::cfg_t cfg;
    logic        latch_s1;
    logic        latch_s2;
    logic        latch_prev;
    logic        oe_s1;
    logic        oe_s2;
    logic        align_s1;
    logic        align_s2;
    logic [3:0]  vco_cnt;
    logic        vco_tick;
    logic        vco_lvl;
    logic [1:0]  pd_cnt;
    logic        lock_tick;
    logic        pin_o;
    logic        pin_oe;
  } st_t;

  st_t st_q;
  st_t st_d;

  // link side: shift register on the serial clock, msb first
  logic [clk_out_cfg_pkg::WORD_W-1:0] link_word_q;

  always_ff @(posedge i_wire_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      link_word_q <= '0;
    end else begin
      link_word_q <= {link_word_q[clk_out_cfg_pkg::WORD_W-2:0], i_wire_data};
    end
  end

  // the word is only sampled after the latch strobe has been synchronised;
  // the serial clock is idle by then, so the word is stable across the crossing
  logic                               latch_rise;
  logic [clk_out_cfg_pkg::ADDR_W-1:0] addr;
  logic                               soft_reset_wr;
  logic                               allow;

  assign latch_rise    = st_q.latch_s2 && !st_q.latch_prev;
  assign addr          = link_word_q[clk_out_cfg_pkg::ADDR_LSB +: clk_out_cfg_pkg::ADDR_W];
  assign soft_reset_wr = latch_rise && addr == clk_out_cfg_pkg::ADDR_CH_FIRST
                         && link_word_q[clk_out_cfg_pkg::SOFT_RESET_BIT];
  // channels run only with gate set, enable pin high and chip awake
  assign allow         = st_q.cfg.gate && st_q.oe_s2 && !st_q.cfg.sleep;

  always_comb begin
    st_d = st_q;

    st_d.latch_s1   = i_wire_latch;
    st_d.latch_s2   = st_q.latch_s1;
    st_d.latch_prev = st_q.latch_s2;
    st_d.oe_s1      = i_output_enable_pin;
    st_d.oe_s2      = st_q.oe_s1;
    st_d.align_s1   = i_align_n;
    st_d.align_s2   = st_q.align_s1;

    // register writes
    // one take per latch edge, so a word is never applied a second time
    if (soft_reset_wr) begin
      st_d.cfg = clk_out_cfg_pkg::CFG_RESET;
    end else if (latch_rise) begin
      if (addr <= clk_out_cfg_pkg::ADDR_CH_LAST) begin
        st_d.cfg.ch[addr[1:0]].path = clk_out_cfg_pkg::path_t'(link_word_q[clk_out_cfg_pkg::PATH_LSB +: 2]);
        st_d.cfg.ch[addr[1:0]].on   = link_word_q[clk_out_cfg_pkg::CH_ON_BIT];
        st_d.cfg.ch[addr[1:0]].div  = link_word_q[clk_out_cfg_pkg::DIV_LSB +: 8];
        st_d.cfg.ch[addr[1:0]].dly  = link_word_q[clk_out_cfg_pkg::DLY_LSB +: 4];
      end
      if (addr == clk_out_cfg_pkg::ADDR_LOCK_SCALE) begin
        st_d.cfg.prescale = link_word_q[clk_out_cfg_pkg::PRESCALE_BIT];
      end
      if (addr == clk_out_cfg_pkg::ADDR_LOOP_REF) begin
        st_d.cfg.ref_mhz     = link_word_q[clk_out_cfg_pkg::REF_MHZ_LSB +: 8];
        st_d.cfg.loop_filter = link_word_q[clk_out_cfg_pkg::LOOP_LSB +: 10];
      end
      if (addr == clk_out_cfg_pkg::ADDR_REF_GLOBAL) begin
        st_d.cfg.fout_on  = link_word_q[clk_out_cfg_pkg::FOUT_BIT];
        st_d.cfg.gate     = link_word_q[clk_out_cfg_pkg::GATE_BIT];
        st_d.cfg.sleep    = link_word_q[clk_out_cfg_pkg::SLEEP_BIT];
        st_d.cfg.lock_sel = link_word_q[clk_out_cfg_pkg::LOCK_SEL_LSB +: 4];
        st_d.cfg.ref_div  = link_word_q[clk_out_cfg_pkg::REF_DIV_LSB +: 12];
      end
      if (addr == clk_out_cfg_pkg::ADDR_FB_PUMP) begin
        st_d.cfg.pump    = link_word_q[clk_out_cfg_pkg::PUMP_LSB +: 2];
        st_d.cfg.osc_div = link_word_q[clk_out_cfg_pkg::OSC_DIV_LSB +: 4];
        st_d.cfg.fb_div  = link_word_q[clk_out_cfg_pkg::FB_DIV_LSB +: 18];
      end
    end

    // oscillator divider: one tick every osc_div system cycles; frozen in sleep
    // level period is 2*osc_div cycles; channels count ticks, so ratios still multiply
    st_d.vco_tick = 1'b0;
    if (!st_q.cfg.sleep && st_q.cfg.osc_div != 4'h0) begin
      if (st_q.vco_cnt >= st_q.cfg.osc_div - 4'h1) begin
        st_d.vco_cnt  = 4'h0;
        st_d.vco_tick = 1'b1;
        st_d.vco_lvl  = ~st_q.vco_lvl;
      end else begin
        st_d.vco_cnt = st_q.vco_cnt + 4'h1;
      end
    end

    // lock detect event rate, optionally divided by four
    st_d.lock_tick = 1'b0;
    if (i_pd_tick) begin
      if (!st_q.cfg.prescale) begin
        st_d.lock_tick = 1'b1;
        st_d.pd_cnt    = 2'h0;
      end else begin
        st_d.pd_cnt    = st_q.pd_cnt + 2'h1;
        st_d.lock_tick = st_q.pd_cnt == clk_out_cfg_pkg::PRESCALE_LAST;
      end
    end

    // lock pin driver
    unique case (st_q.cfg.lock_sel)
      clk_out_cfg_pkg::LOCK_HIGH: begin
        st_d.pin_o  = 1'b1;
        st_d.pin_oe = 1'b1;
      end
      clk_out_cfg_pkg::LOCK_LOW: begin
        st_d.pin_o  = 1'b0;
        st_d.pin_oe = 1'b1;
      end
      clk_out_cfg_pkg::LOCK_DIG_HI, clk_out_cfg_pkg::LOCK_ANALOG: begin
        st_d.pin_o  = i_lock_detect;
        st_d.pin_oe = 1'b1;
      end
      clk_out_cfg_pkg::LOCK_DIG_LO: begin
        st_d.pin_o  = ~i_lock_detect;
        st_d.pin_oe = 1'b1;
      end
      clk_out_cfg_pkg::LOCK_OD_NMOS: begin
        st_d.pin_o  = 1'b0;
        st_d.pin_oe = ~i_lock_detect;
      end
      clk_out_cfg_pkg::LOCK_OD_PMOS: begin
        st_d.pin_o  = 1'b1;
        st_d.pin_oe = i_lock_detect;
      end
      // off and undefined codes leave the pin floating
      default: begin
        st_d.pin_o  = 1'b0;
        st_d.pin_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= '{cfg: clk_out_cfg_pkg::CFG_RESET, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // channels; alignment holds every divider at phase zero while the pin is low
  for (genvar g = 0; g < clk_out_cfg_pkg::NUM_CH; g++) begin : g_ch
    clk_channel_path u_ch (
      .i_clk            (i_clk),
      .i_arst_n         (i_arst_n),
      .i_vco_tick       (st_q.vco_tick),
      .i_vco_lvl        (st_q.vco_lvl),
      .i_align          (!st_q.align_s2),
      .i_allow          (allow),
      .i_cfg            (st_q.cfg.ch[g]),
      .o_clk            (o_clk_out[g]),
      .o_added_delay_ps (o_added_delay_ps[g])
    );
  end

  assign o_oscillator_divide_code_clk       = st_q.vco_lvl;
  assign o_fout_on           = st_q.cfg.fout_on;
  assign o_chip_sleep        = st_q.cfg.sleep;
  assign o_lock_tick         = st_q.lock_tick;
  assign o_lock_pin_o        = st_q.pin_o;
  assign o_lock_pin_oe       = st_q.pin_oe;
  assign o_ref_input_mhz     = st_q.cfg.ref_mhz;
  assign o_loop_filter       = st_q.cfg.loop_filter;
  assign o_ref_div           = st_q.cfg.ref_div;
  assign o_fb_div            = st_q.cfg.fb_div;
  assign o_pump_current_code = st_q.cfg.pump;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  property p_soft_reset_defaults;
    soft_reset_wr |=> (st_q.cfg == clk_out_cfg_pkg::CFG_RESET);
  endproperty
  a_soft_reset_defaults: assert property (p_soft_reset_defaults) else $error("soft reset left a non-default field");

  property p_reset_ignores_fields;
    soft_reset_wr |=> (st_q.cfg.ch[0].path == clk_out_cfg_pkg::PATH_BYPASS && st_q.cfg.ch[0].div == 8'h01
                       && !st_q.cfg.ch[0].on);
  endproperty
  a_reset_ignores_fields: assert property (p_reset_ignores_fields) else $error("soft reset write stored fields");

  property p_channel_write;
    (latch_rise && !soft_reset_wr && addr <= clk_out_cfg_pkg::ADDR_CH_LAST)
      |=> (st_q.cfg.ch[$past(addr[1:0])].path == $past(link_word_q[18:17])
           && st_q.cfg.ch[$past(addr[1:0])].div == $past(link_word_q[15:8])
           && st_q.cfg.ch[$past(addr[1:0])].on == $past(link_word_q[clk_out_cfg_pkg::CH_ON_BIT])
           && st_q.cfg.ch[$past(addr[1:0])].dly == $past(link_word_q[clk_out_cfg_pkg::DLY_LSB +: 4]));
  endproperty
  a_channel_write: assert property (p_channel_write) else $error("channel fields not stored from word");

  property p_gate_kills;
    (!allow)[*2] |-> (o_clk_out == '0);
  endproperty
  a_gate_kills: assert property (p_gate_kills) else $error("clock output active while gated");

  property p_prescale_off;
    (!st_q.cfg.prescale && i_pd_tick) |=> o_lock_tick;
  endproperty
  a_prescale_off: assert property (p_prescale_off) else $error("undivided lock event lost");

  property p_prescale_spacing;
    (st_q.cfg.prescale && o_lock_tick) ##1 st_q.cfg.prescale [*3] |-> !o_lock_tick;
  endproperty
  a_prescale_spacing: assert property (p_prescale_spacing) else $error("divided lock events closer than four");

  property p_lock_off;
    (st_q.cfg.lock_sel == clk_out_cfg_pkg::LOCK_OFF) |=> !o_lock_pin_oe;
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("lock pin driven while disabled");

  property p_power_defaults;
    soft_reset_wr |=> (st_q.cfg.gate && !st_q.cfg.sleep && st_q.cfg.lock_sel == 4'h0) ##1 (o_chip_sleep == 1'b0);
  endproperty
  a_power_defaults: assert property (p_power_defaults) else $error("gate or sleep default wrong");

  property p_ref_defaults;
    soft_reset_wr |=> (o_ref_input_mhz == 8'h0A && !st_q.cfg.prescale);
  endproperty
  a_ref_defaults: assert property (p_ref_defaults) else $error("reference default not 10 MHz");

  // stored fields are compared with the word as it stood at the take
  property p_ref_write;
    (latch_rise && addr == clk_out_cfg_pkg::ADDR_LOOP_REF)
      |=> (o_ref_input_mhz == $past(link_word_q[clk_out_cfg_pkg::REF_MHZ_LSB +: 8]));
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("reference field not stored");

  property p_prescale_write;
    (latch_rise && addr == clk_out_cfg_pkg::ADDR_LOCK_SCALE)
      |=> (st_q.cfg.prescale == $past(link_word_q[clk_out_cfg_pkg::PRESCALE_BIT]));
  endproperty
  a_prescale_write: assert property (p_prescale_write) else $error("prescale bit not stored");

  property p_global_write;
    (latch_rise && addr == clk_out_cfg_pkg::ADDR_REF_GLOBAL)
      |=> (st_q.cfg.gate == $past(link_word_q[clk_out_cfg_pkg::GATE_BIT])
           && o_chip_sleep == $past(link_word_q[clk_out_cfg_pkg::SLEEP_BIT]));
  endproperty
  a_global_write: assert property (p_global_write) else $error("gate or sleep not stored");

  property p_unmapped_ignored;
    (latch_rise && addr > clk_out_cfg_pkg::ADDR_CH_LAST && addr < clk_out_cfg_pkg::ADDR_LOOP_REF
     && addr != clk_out_cfg_pkg::ADDR_LOCK_SCALE) |=> $stable(st_q.cfg);
  endproperty
  a_unmapped_ignored: assert property (p_unmapped_ignored) else $error("unmapped write changed a field");

  property p_pin_low_gates;
    !st_q.oe_s2
      |=> (o_clk_out == '0);
  endproperty
  a_pin_low_gates: assert property (p_pin_low_gates) else $error("output active with enable pin low");

  property p_sleep_freezes;
    st_q.cfg.sleep
      |=> (!st_q.vco_tick && o_clk_out == '0);
  endproperty
  a_sleep_freezes: assert property (p_sleep_freezes) else $error("divider or output ran in sleep");

  property p_vco_toggle;
    st_q.vco_tick
      |-> (o_oscillator_divide_code_clk != $past(o_oscillator_divide_code_clk));
  endproperty
  a_vco_toggle: assert property (p_vco_toggle) else $error("oscillator level missed its tick");

  property p_lock_follow;
    (st_q.cfg.lock_sel == clk_out_cfg_pkg::LOCK_DIG_HI)
      |=> (o_lock_pin_oe && o_lock_pin_o == $past(i_lock_detect));
  endproperty
  a_lock_follow: assert property (p_lock_follow) else $error("lock pin not following lock detect");

  property p_open_drain;
    (st_q.cfg.lock_sel == clk_out_cfg_pkg::LOCK_OD_NMOS)
      |=> (!o_lock_pin_o && o_lock_pin_oe == !$past(i_lock_detect));
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain lock pin misdriven");

  c_soft_reset: cover property (soft_reset_wr);
  c_global_write: cover property (latch_rise && addr == clk_out_cfg_pkg::ADDR_REF_GLOBAL);
  c_prescaled_tick: cover property (st_q.cfg.prescale && o_lock_tick);
  c_align_release: cover property ($rose(st_q.align_s2));

endmodule
`default_nettype wire

// ---- tb/host_serial_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
  output logic o_wire_clk,
  output logic o_wire_data,
  output logic o_wire_latch
);
  initial begin
    o_wire_clk   = 1'b0;
    o_wire_data  = 1'b0;
    o_wire_latch = 1'b0;
  end
  // wire clock only runs inside a frame, 125 ns period
  task automatic send(input logic [31:0] w);
    for (int k = 31; k >= 0; k--) begin
      o_wire_data = w[k];
      #31;
      o_wire_clk = 1'b1;
      #62.5;
      o_wire_clk = 1'b0;
      #31.5;
    end
    // released data line must not look like a held bit
    o_wire_data  = ~w[0];
    o_wire_latch = 1'b1;
    #400;
    o_wire_latch = 1'b0;
    #300;
  endtask
endmodule
`default_nettype wire

// ---- tb/clock_output_path_config_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module clock_output_path_config_tb_top;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_align_n = 1'b1;
  logic i_output_enable_pin = 1'b1;
  logic i_pd_tick = 1'b0;
  logic i_lock_detect = 1'b0;
  logic wclk, wdat, wlat;
  logic [3:0] o_clk_out;
  logic [3:0][11:0] o_added_delay_ps;
  logic vco, fout, slp, ltick, lpo, lpoe;
  logic [7:0] mhz;
  logic [9:0] loopf;
  logic [11:0] rdiv;
  logic [17:0] fbd;
  logic [1:0] pump;
  int n_errors = 0;
  int compares = 0;

  always #25 i_clk = ~i_clk;

  clock_output_path_config i_dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_wire_clk(wclk), .i_wire_data(wdat),
    .i_wire_latch(wlat), .i_align_n(i_align_n), .i_output_enable_pin(i_output_enable_pin),
    .i_pd_tick(i_pd_tick), .i_lock_detect(i_lock_detect), .o_clk_out(o_clk_out),
    .o_added_delay_ps(o_added_delay_ps), .o_oscillator_divide_code_clk(vco), .o_fout_on(fout),
    .o_chip_sleep(slp), .o_lock_tick(ltick), .o_lock_pin_o(lpo), .o_lock_pin_oe(lpoe),
    .o_ref_input_mhz(mhz), .o_loop_filter(loopf), .o_ref_div(rdiv), .o_fb_div(fbd),
    .o_pump_current_code(pump));

  host_serial_model i_host (.o_wire_clk(wclk), .o_wire_data(wdat), .o_wire_latch(wlat));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string m);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s seen %0h exp %0h", $time, m, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // chw leaves bit 31 clear; only the t_soft_reset word sets it on register 0
  function automatic logic [31:0] chw(logic [3:0] a, logic [1:0] p, logic [7:0] d, logic [3:0] y);
    return {13'h0000, p, 1'b1, d, y, a};
  endfunction
  function automatic logic [31:0] r14(logic f, logic g, logic s, logic [3:0] l, logic [11:0] r);
    return {3'h0, f, g, s, 2'h0, l, r, 4'h0, clk_out_cfg_pkg::ADDR_REF_GLOBAL};
  endfunction

  task automatic wr(input logic [31:0] w);
    i_host.send(w);
    repeat (2) @(negedge i_clk);
  endtask

  task automatic align();
    @(negedge i_clk) i_align_n = 1'b0;
    repeat (3) @(negedge i_clk);
    i_align_n = 1'b1;
    repeat (4) @(negedge i_clk);
  endtask

  task automatic period(input int ch, output int p);
    int e;
    logic prev, cur;
    e = 0;
    p = 0;
    prev = 1'b1;
    for (int n = 0; n < 600 && e < 2; n++) begin
      @(negedge i_clk);
      cur = (ch < 0) ? vco : o_clk_out[ch];
      if (e == 1) p++;
      if (cur === 1'b1 && prev === 1'b0) e++;
      prev = cur;
    end
  endtask

  task automatic quiet(input string m);
    int hi;
    hi = 0;
    repeat (4) @(negedge i_clk);
    repeat (24) @(negedge i_clk) if (o_clk_out !== 4'h0) hi++;
    chk(hi, 0, m);
  endtask

  task automatic t_defaults();
    chk(mhz, 8'h0A, "ref mhz default");
    chk({rdiv, fbd, pump}, {12'h00A, 18'h002F8, 2'h0}, "divider defaults");
    chk({fout, slp, loopf}, 12'h000, "fout sleep loop");
    chk(lpoe, 1'b0, "lock pin off");
    chk(o_added_delay_ps, 48'h0, "delays bypass");
    chk(o_clk_out, 4'h0, "channels off");
    $display("done defaults");
  endtask

  task automatic t_divider();
    int p, v;
    wr(chw(4'h0, 2'h1, 8'h03, 4'h0));
    wr(chw(4'h1, 2'h0, 8'h03, 4'h0));
    wr(chw(4'h2, 2'h2, 8'h03, 4'h0));
    align();
    period(-1, v);
    chk(v, 4, "vco period");
    period(0, p);
    chk(p, 6 * v, "divide by 6");
    period(1, p);
    chk(p, v, "bypass ignores divider");
    period(2, p);
    chk(p, v, "delayed not divided");
    wr(chw(4'h7, 2'h3, 8'h01, 4'h0));
    wr({2'h0, 4'h3, 18'h002F8, 4'h0, clk_out_cfg_pkg::ADDR_FB_PUMP});
    align();
    period(-1, v);
    chk(v, 6, "vco period osc 3");
    period(3, p);
    chk(p, 2 * v, "divide by 2 on alias");
    $display("done divider");
  endtask

  task automatic t_gate();
    int p;
    wr(r14(1'b0, 1'b0, 1'b0, 4'h0, 12'h00A));
    quiet("gate off");
    wr(r14(1'b0, 1'b1, 1'b0, 4'h0, 12'h00A));
    @(negedge i_clk) i_output_enable_pin = 1'b0;
    quiet("pin low");
    i_output_enable_pin = 1'b1;
    wr(r14(1'b0, 1'b1, 1'b1, 4'h0, 12'h00A));
    chk(slp, 1'b1, "sleep set");
    quiet("asleep");
    wr(r14(1'b0, 1'b1, 1'b0, 4'h0, 12'h00A));
    repeat (4) @(negedge i_clk);
    period(1, p);
    chk(p, 6, "running again");
    $display("done gate");
  endtask

  task automatic t_fields();
    logic [3:0] bad [4] = '{4'h8, 4'h9, 4'hA, 4'hC};
    wr({10'h000, 8'hC8, 10'h3FF, clk_out_cfg_pkg::ADDR_LOOP_REF});
    wr(r14(1'b1, 1'b1, 1'b0, 4'h0, 12'hFFF));
    wr({2'h3, 4'h3, 18'h3FFFF, 4'h0, clk_out_cfg_pkg::ADDR_FB_PUMP});
    foreach (bad[i]) wr({28'h0000000, bad[i]});
    chk({mhz, loopf}, {8'hC8, 10'h3FF}, "loop and ref fields");
    chk({fout, rdiv, fbd, pump}, {1'b1, 12'hFFF, 18'h3FFFF, 2'h3}, "globals kept");
    $display("done fields");
  endtask

  task automatic t_lock();
    int c;
    logic e, oe;
    for (int pre = 0; pre < 2; pre++) begin
      if (pre == 1) wr({16'h0000, 1'b1, 11'h000, clk_out_cfg_pkg::ADDR_LOCK_SCALE});
      c = 0;
      for (int n = 0; n < 32; n++) begin
        @(negedge i_clk);
        if (ltick === 1'b1) c++;
        i_pd_tick = (n % 4 == 0 && n < 29);
      end
      chk(c, pre ? 2 : 8, "lock ticks");
    end
    for (int m = 0; m < 9; m++) begin
      wr(r14(1'b1, 1'b1, 1'b0, m[3:0], 12'hFFF));
      for (int ld = 0; ld < 2; ld++) begin
        @(negedge i_clk) i_lock_detect = ld[0];
        repeat (3) @(negedge i_clk);
        e = (m == 1) | (m == 7) | ((m == 3 | m == 5) & ld == 1) | (m == 4 & ld == 0);
        oe = (m > 0 & m < 6) | (m == 6 & ld == 0) | (m == 7 & ld == 1);
        chk(lpoe, oe, "lock pin drive");
        if (oe) chk(lpo, e, "lock pin level");
      end
    end
    $display("done lock");
  endtask

  task automatic t_delays();
    logic [11:0] exp [4] = '{12'h000, 12'h064, 12'h352, 12'h3B6};
    for (int k = 0; k < 4; k++) begin
      wr(chw(k[3:0], k[1:0], 8'h01, 4'h3));
      chk(o_added_delay_ps[k], exp[k], "path delay");
    end
    wr(chw(4'h3, 2'h3, 8'h01, 4'hF));
    chk(o_added_delay_ps[3], 12'hABE, "max delay");
    $display("done delays");
  endtask

  task automatic t_soft_reset();
    wr({1'b1, 12'h000, 2'h3, 1'b1, 8'h05, 4'h2, clk_out_cfg_pkg::ADDR_CH_FIRST});
    chk({mhz, rdiv, fbd, fout}, {8'h0A, 12'h00A, 18'h002F8, 1'b0}, "all defaults");
    chk(o_added_delay_ps, 48'h0, "reset word fields ignored");
    wr(chw(4'h0, 2'h3, 8'h05, 4'h2));
    chk(o_added_delay_ps[0], 12'h320, "rewrite after reset");
    $display("done soft reset");
  endtask

  initial begin
    #3000000;
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (4) @(negedge i_clk);
    i_arst_n = 1'b1;
    repeat (3) @(negedge i_clk);
    t_defaults();
    t_divider();
    t_gate();
    t_fields();
    t_lock();
    t_delays();
    t_soft_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
